// *** logic/sshi_pkg.sv ***
package sshi_pkg;
    // ==================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SMB_DETECT_MS = 75;
    localparam int COMP_DETECT_US = 75;
    localparam int SMB_IDLE_MS = 30;
    localparam int SMB_DETECT_CYC = SMB_DETECT_MS * (CLK_HZ / 1000);
    localparam int COMP_DETECT_CYC = COMP_DETECT_US * (CLK_HZ / 1_000_000);
    localparam int SMB_IDLE_CYC = SMB_IDLE_MS * (CLK_HZ / 1000);

    // ==================================================
    // Register offsets
    localparam logic [7:0] OFF_RESET = 8'hF5;
    localparam logic [7:0] OFF_TEST = 8'hF6;
    localparam logic [7:0] OFF_CLKCTL = 8'hFA;
    localparam logic [7:0] OFF_WAKE = 8'hFB;
    localparam logic [7:0] OFF_PARTID = 8'hFC;
    localparam logic [7:0] OFF_REV = 8'hFD;
    localparam logic [7:0] OFF_MAKER_LO = 8'hFE;
    localparam logic [7:0] OFF_MAKER_HI = 8'hFF;

    // ==================================================
    // Field positions and reset values
    localparam int CC_ARA_BIT = 4;
    localparam int CC_OSC_BIT = 2;
    localparam int WK_GPIO_BIT = 2;
    localparam int WK_DAT_BIT = 1;
    localparam int WK_CLK_BIT = 0;
    localparam int RST_FORCE_BIT = 0;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [2:0] WAKE_RST = 3'h0;
    localparam logic [7:0] TEST_VAL = 8'h00;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [1:0] SEL_COMP = 2'h2;
    localparam logic [1:0] SEL_SMB = 2'h3;

    // ==================================================
    // Addresses
    localparam logic [5:0] ADDR_BASE = 6'h1C;
    localparam logic [4:0] ADDR_MATCH5 = 5'h0E;
    localparam logic [6:0] ARA_ADDR = 7'h0C;

    typedef enum logic [1:0] {
        BUS_NONE = 2'h0,
        BUS_SMB = 2'h1,
        BUS_COMP = 2'h3
    } sshi_bus_e;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_AACK = 4'h3,
        S_CMD = 4'h2,
        S_CACK = 4'h6,
        S_DATA = 4'h7,
        S_DACK = 4'h5,
        S_TX = 4'h4,
        S_TACK = 4'hC,
        S_DONE = 4'hD
    } sshi_state_e;
endpackage

// *** logic/sshi_top.sv ***
// Notes on behaviour
// R1 - Gpio wake enable lets enabled pin interrupts restart a stopped oscillator.
// R2 - Data or clock wake enable lets any edge on that line restart oscillator.
// R3 - Pin edges count only on inputs with their edge type configured.
// R4 - Part identification register reads a fixed code.
// R5 - Maker code low and high registers read fixed values.
// R6 - Writing one to force bit resets everything except selection field and bus type; bit self clears.
// R7 - Forced reset keeps bus selection field and chosen bus.
// R8 - From idle, first clock fall samples data: low picks SMBus, high companion.
// R9 - Power-on or long bus silence is idle and allows a new bus choice.
// R10 - Per-bus timeout reloads on SMBus start or companion clock edge: long for SMBus, short for companion.
// R11 - Master clocks SMBus between the minimum and maximum bus rates.
// R12 - Slave logic runs from the internal oscillator clock.
// R13 - Address comes from select pin, latched on first five-bit-matching transaction.
// R14 - Address is 0111000 with select low, 0111001 with select high.
// R15 - Slave only; accepts write, read, send and receive byte only.
// R16 - Register write lands only after complete write byte frame and stop.
// R17 - Read byte: index, repeated start, read address, one byte, nack, stop.
// R18 - Send byte loads the pointer and moves no data.
// R19 - Receive byte returns the register at the current pointer.
// R20 - Clock held low by others is waited out before continuing.
// R21 - Alert response enable makes device answer the alert response address.
// R22 - SMBus inactivity timeout returns the interface to idle.
// R23 - Selection field: 0X autodetect, 10 companion, 11 SMBus.
// R24 - Alert response disabled means alert address is ignored.
// R25 - Low power oscillator stops only when idle, done and nothing pending.
// R26 - Malformed or aborted transactions leave registers unchanged.
`timescale 1ns/10ps
module sshi_top #(
    parameter int GPIO_N = 8,
    parameter int DET_SMB_CYC = sshi_pkg::SMB_DETECT_CYC,
    parameter int IDLE_SMB_CYC = sshi_pkg::SMB_IDLE_CYC,
    parameter logic [7:0] PART_ID = 8'hA7, // Arbitrary value
    parameter logic [7:0] REV_ID = 8'h03, // Arbitrary value
    parameter logic [15:0] MAKER_ID = 16'h6B2D // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic smbusClockPin,
    input wire logic smbusDataPin,
    output logic smbusDataOut,
    output logic smbusDataOe,
    input wire logic addrSelectPin,
    input wire logic [GPIO_N-1:0] gpioPin,
    input wire logic [GPIO_N-1:0] gpioFuncSel,
    input wire logic [GPIO_N-1:0] gpioIrqEn,
    input wire logic [GPIO_N-1:0] gpioDirIn,
    input wire logic [GPIO_N-1:0] gpioRiseEn,
    input wire logic [GPIO_N-1:0] gpioFallEn,
    input wire logic irqPending,
    output logic oscRun,
    output logic smbusActive,
    output logic companionActive,
    output logic [GPIO_N-1:0] gpioEdgeEvent,
    output logic [6:0] slaveAddr,
    output logic addrLocked
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ==================================================
    // Pin synchronisers and edge detection
    logic [GPIO_N+2:0] sync1_ff;
    logic [GPIO_N+2:0] sync2_ff;
    logic sclP_ff;
    logic sdaP_ff;
    logic [GPIO_N-1:0] gpioP_ff;

    // Two flops for every pin level
    always_ff @(posedge clk or negedge rst_b) begin
        // Bus lines idle high, strap and pins low, matching the edge history flops
        if (!rst_b) begin
            sync1_ff <= {3'h3, {GPIO_N{1'h0}}};
            sync2_ff <= {3'h3, {GPIO_N{1'h0}}};
        end else begin
            sync1_ff <= {addrSelectPin, smbusDataPin, smbusClockPin, gpioPin};
            sync2_ff <= sync1_ff;
        end
    end

    // Previous levels for edge finding
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclP_ff <= 1'b1;
            sdaP_ff <= 1'b1;
            gpioP_ff <= '0;
        end else begin
            sclP_ff <= sync2_ff[GPIO_N];
            sdaP_ff <= sync2_ff[GPIO_N+1];
            gpioP_ff <= sync2_ff[GPIO_N-1:0];
        end
    end

    wire sclS = sync2_ff[GPIO_N];
    wire sdaS = sync2_ff[GPIO_N+1];
    wire addrSelS = sync2_ff[GPIO_N+2];
    wire [GPIO_N-1:0] gpioS = sync2_ff[GPIO_N-1:0];
    // Edges are seen only on the real line level, so a stretched clock just waits
    wire sclRise = sclS & ~sclP_ff; // R20
    wire sclFall = ~sclS & sclP_ff;
    wire sdaEdge = sdaS ^ sdaP_ff;
    wire lineEdge = sdaEdge | sclRise | sclFall;
    wire [GPIO_N-1:0] gpioEv = ((gpioS & ~gpioP_ff & gpioRiseEn) |
                                (~gpioS & gpioP_ff & gpioFallEn)) & gpioDirIn; // R3

    // ==================================================
    // Control registers and bus selection
    logic softRst_ff;
    logic araEn_ff;
    logic oscLp_ff;
    logic [1:0] sel_ff;
    logic [2:0] wake_ff;
    logic [7:0] ptr_ff;
    logic [7:0] cmd_ff;
    logic [7:0] wrData_ff;
    logic wrPend_ff;
    logic cmdPend_ff;
    sshi_pkg::sshi_bus_e busType_ff;
    sshi_pkg::sshi_state_e st_ff;
    logic [3:0] bitCnt_ff;

    // Forced selection overrides the detected bus type
    wire forced = sel_ff[1]; // R23
    wire smbOn = forced ? sel_ff[0] : (busType_ff != sshi_pkg::BUS_COMP); // R23
    wire compOn = forced ? ~sel_ff[0] : (busType_ff == sshi_pkg::BUS_COMP);
    wire startDet = smbOn & sclS & sclP_ff & sdaP_ff & ~sdaS;
    wire stopDet = smbOn & sclS & sclP_ff & ~sdaP_ff & sdaS;
    wire sendOk = cmdPend_ff & ~wrPend_ff & (st_ff == sshi_pkg::S_DATA) & (bitCnt_ff <= 4'h1);
    wire commit = stopDet & wrPend_ff & (st_ff == sshi_pkg::S_DONE); // R16 R26
    wire wrClk = commit & (cmd_ff == sshi_pkg::OFF_CLKCTL);
    wire wrWake = commit & (cmd_ff == sshi_pkg::OFF_WAKE);
    wire wrRst = commit & (cmd_ff == sshi_pkg::OFF_RESET) & wrData_ff[sshi_pkg::RST_FORCE_BIT];

    // Forced reset pulse; writing zero does nothing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            softRst_ff <= 1'b0;
        end else begin
            softRst_ff <= wrRst; // R6
        end
    end

    // Clock and wake control, cleared by forced reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            araEn_ff <= 1'b0;
            oscLp_ff <= 1'b0;
            wake_ff <= sshi_pkg::WAKE_RST;
        end else if (softRst_ff) begin
            araEn_ff <= 1'b0; // R6
            oscLp_ff <= 1'b0;
            wake_ff <= sshi_pkg::WAKE_RST;
        end else begin
            if (wrClk) begin
                araEn_ff <= wrData_ff[sshi_pkg::CC_ARA_BIT];
                oscLp_ff <= wrData_ff[sshi_pkg::CC_OSC_BIT];
            end
            if (wrWake) begin
                wake_ff <= wrData_ff[2:0];
            end
        end
    end

    // Selection field survives forced reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_ff <= sshi_pkg::SEL_RST;
        end else if (wrClk) begin
            sel_ff <= wrData_ff[1:0]; // R7
        end
    end

    // ==================================================
    // Autodetect with per-bus reload timeout
    logic [19:0] detTmr_ff;
    wire detDecide = ~forced & (busType_ff == sshi_pkg::BUS_NONE) & sclFall; // R8
    wire detExpire = (busType_ff != sshi_pkg::BUS_NONE) & (detTmr_ff == 20'h0); // R9
    wire detReload = detDecide |
                     ((busType_ff == sshi_pkg::BUS_SMB) & startDet) |
                     ((busType_ff == sshi_pkg::BUS_COMP) & (sclRise | sclFall)); // R10
    wire pickComp = detDecide ? sdaS : (busType_ff == sshi_pkg::BUS_COMP);
    wire [19:0] detLoad = pickComp ? 20'(sshi_pkg::COMP_DETECT_CYC - 1) : 20'(DET_SMB_CYC - 1);

    // Bus type is kept across forced reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busType_ff <= sshi_pkg::BUS_NONE;
            detTmr_ff <= 20'h0;
        end else if (detReload) begin
            if (detDecide) begin
                busType_ff <= sdaS ? sshi_pkg::BUS_COMP : sshi_pkg::BUS_SMB; // R8
            end
            detTmr_ff <= detLoad; // R10
        end else if (detExpire) begin
            busType_ff <= sshi_pkg::BUS_NONE; // R9
        end else if (busType_ff != sshi_pkg::BUS_NONE) begin
            detTmr_ff <= detTmr_ff - 20'h1;
        end
    end

    a_detect_pick: assert property (detDecide && !sdaS |=> busType_ff == sshi_pkg::BUS_SMB) // R8
        else $error("autodetect did not pick SMBus on low data");
    a_detect_expire: assert property (detExpire && !detReload
        |=> busType_ff == sshi_pkg::BUS_NONE) // R9
        else $error("autodetect did not return to idle");

    // ==================================================
    // Slave address selection
    logic [6:0] myAddr_ff;
    logic locked_ff;
    logic [7:0] shift_ff;
    logic isAra_ff;
    wire [6:0] liveAddr = {sshi_pkg::ADDR_BASE, addrSelS}; // R14
    wire [6:0] ownAddr = locked_ff ? myAddr_ff : liveAddr;
    wire byteDone = sclFall & (bitCnt_ff == 4'h8);
    wire ownHit = shift_ff[7:1] == ownAddr;
    wire araHit = araEn_ff & smbOn & shift_ff[0] & (shift_ff[7:1] == sshi_pkg::ARA_ADDR); // R21 R24
    wire addrEnd = (st_ff == sshi_pkg::S_ADDR) & byteDone;

    // Latch address on first transaction whose five upper bits match
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            locked_ff <= 1'b0;
            myAddr_ff <= 7'h00;
        end else if (softRst_ff) begin
            locked_ff <= 1'b0;
        end else if (addrEnd & ~locked_ff & (shift_ff[7:3] == sshi_pkg::ADDR_MATCH5)) begin
            locked_ff <= 1'b1; // R13
            myAddr_ff <= liveAddr;
        end
    end

    // ==================================================
    // Register read selection
    logic [7:0] regRd;
    always_comb begin
        case (ptr_ff)
            sshi_pkg::OFF_TEST: regRd = sshi_pkg::TEST_VAL;
            sshi_pkg::OFF_CLKCTL: regRd = {3'h0, araEn_ff, 1'b0, oscLp_ff, sel_ff};
            sshi_pkg::OFF_WAKE: regRd = {5'h00, wake_ff};
            sshi_pkg::OFF_PARTID: regRd = PART_ID; // R4
            sshi_pkg::OFF_REV: regRd = REV_ID;
            sshi_pkg::OFF_MAKER_LO: regRd = MAKER_ID[7:0]; // R5
            sshi_pkg::OFF_MAKER_HI: regRd = MAKER_ID[15:8]; // R5
            default: regRd = 8'h00;
        endcase
    end
    wire [7:0] readByte = isAra_ff ? {ownAddr, 1'b0} : regRd; // R19

    a_part_code: assert property (ptr_ff == sshi_pkg::OFF_PARTID |-> regRd == PART_ID) // R4
        else $error("part identification read wrong");
    a_maker_code: assert property (ptr_ff == sshi_pkg::OFF_MAKER_HI
        |-> regRd == MAKER_ID[15:8]) // R5
        else $error("maker code high read wrong");

    // ==================================================
    // SMBus slave engine
    logic [7:0] tx_ff;
    logic oe_ff;
    logic isRead_ff;
    logic [19:0] idleTmr_ff;
    wire smbTimeout = (st_ff != sshi_pkg::S_IDLE) & (idleTmr_ff == 20'h0); // R22

    sshi_pkg::sshi_state_e nxt_st;
    logic [3:0] nxt_bitCnt;
    logic [7:0] nxt_shift;
    logic [7:0] nxt_tx;
    logic [7:0] nxt_cmd;
    logic [7:0] nxt_wrData;
    logic nxt_oe;
    logic nxt_isRead;
    logic nxt_isAra;
    logic nxt_cmdPend;
    logic nxt_wrPend;

    // Protocol sequencing for the four supported frames
    always_comb begin
        nxt_st = st_ff;
        nxt_bitCnt = sclRise ? bitCnt_ff + 4'h1 : bitCnt_ff;
        nxt_shift = sclRise ? {shift_ff[6:0], sdaS} : shift_ff;
        nxt_tx = tx_ff;
        nxt_cmd = cmd_ff;
        nxt_wrData = wrData_ff;
        nxt_oe = oe_ff;
        nxt_isRead = isRead_ff;
        nxt_isAra = isAra_ff;
        nxt_cmdPend = cmdPend_ff;
        nxt_wrPend = wrPend_ff;
        case (st_ff)
            sshi_pkg::S_ADDR: if (byteDone) begin
                nxt_isRead = shift_ff[0];
                nxt_isAra = araHit & ~ownHit;
                if (ownHit | araHit) begin // R13 R21
                    nxt_oe = 1'b1;
                    nxt_st = sshi_pkg::S_AACK;
                end else begin
                    nxt_st = sshi_pkg::S_DONE;
                end
            end
            sshi_pkg::S_AACK: if (sclFall) begin
                nxt_bitCnt = 4'h0;
                if (isRead_ff) begin
                    nxt_oe = ~readByte[7]; // R17 R19
                    nxt_tx = {readByte[6:0], 1'b0};
                    nxt_st = sshi_pkg::S_TX;
                end else begin
                    nxt_oe = 1'b0;
                    nxt_st = sshi_pkg::S_CMD;
                end
            end
            sshi_pkg::S_CMD: if (byteDone) begin
                nxt_cmd = shift_ff;
                nxt_cmdPend = 1'b1;
                nxt_oe = 1'b1;
                nxt_st = sshi_pkg::S_CACK;
            end
            sshi_pkg::S_CACK: if (sclFall) begin
                nxt_oe = 1'b0;
                nxt_bitCnt = 4'h0;
                nxt_st = sshi_pkg::S_DATA;
            end
            sshi_pkg::S_DATA: if (byteDone) begin
                nxt_wrData = shift_ff;
                nxt_wrPend = 1'b1; // R16
                nxt_oe = 1'b1;
                nxt_st = sshi_pkg::S_DACK;
            end
            sshi_pkg::S_DACK: if (sclFall) begin
                nxt_oe = 1'b0;
                nxt_st = sshi_pkg::S_DONE;
            end
            sshi_pkg::S_TX: if (sclFall) begin
                if (bitCnt_ff == 4'h8) begin
                    nxt_oe = 1'b0;
                    nxt_st = sshi_pkg::S_TACK;
                end else begin
                    nxt_oe = ~tx_ff[7];
                    nxt_tx = {tx_ff[6:0], 1'b0};
                end
            end
            sshi_pkg::S_TACK: if (sclRise) begin
                nxt_st = sshi_pkg::S_DONE; // R19
            end
            sshi_pkg::S_DONE: if (sclFall) begin // Stop rises here, extra bits fall
                nxt_cmdPend = 1'b0; // R15 R26
                nxt_wrPend = 1'b0;
            end
            default: begin
                nxt_st = st_ff;
            end
        endcase
        if (startDet) begin
            nxt_st = sshi_pkg::S_ADDR;
            nxt_bitCnt = 4'h0;
            nxt_oe = 1'b0;
            nxt_cmdPend = 1'b0;
            nxt_wrPend = 1'b0;
        end
        if (stopDet | smbTimeout | softRst_ff) begin
            nxt_st = sshi_pkg::S_IDLE; // R22
            nxt_bitCnt = 4'h0;
            nxt_oe = 1'b0;
            nxt_cmdPend = 1'b0;
            nxt_wrPend = 1'b0;
        end
    end

    // Engine state
    always_ff @(posedge clk or negedge rst_b) begin // R12
        if (!rst_b) begin
            st_ff <= sshi_pkg::S_IDLE;
            bitCnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            oe_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            bitCnt_ff <= nxt_bitCnt;
            shift_ff <= nxt_shift;
            tx_ff <= nxt_tx;
            oe_ff <= nxt_oe;
        end
    end

    // Transaction context
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_ff <= 8'h00;
            wrData_ff <= 8'h00;
            isRead_ff <= 1'b0;
            isAra_ff <= 1'b0;
            cmdPend_ff <= 1'b0;
            wrPend_ff <= 1'b0;
        end else begin
            cmd_ff <= nxt_cmd;
            wrData_ff <= nxt_wrData;
            isRead_ff <= nxt_isRead;
            isAra_ff <= nxt_isAra;
            cmdPend_ff <= nxt_cmdPend;
            wrPend_ff <= nxt_wrPend;
        end
    end

    // Pointer: write or send at stop, read index at repeated start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_ff <= sshi_pkg::PTR_RST;
        end else if (softRst_ff) begin
            ptr_ff <= sshi_pkg::PTR_RST;
        end else if (commit | (stopDet & sendOk) | (startDet & sendOk)) begin
            ptr_ff <= cmd_ff; // R18 R17
        end
    end

    // Inactivity timer reloads on any line edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idleTmr_ff <= 20'(IDLE_SMB_CYC - 1);
        end else if (lineEdge | (st_ff == sshi_pkg::S_IDLE)) begin
            idleTmr_ff <= 20'(IDLE_SMB_CYC - 1);
        end else if (idleTmr_ff != 20'h0) begin
            idleTmr_ff <= idleTmr_ff - 20'h1; // R22
        end
    end

    sequence s_addr_hit;
        (st_ff == sshi_pkg::S_ADDR) && byteDone && ownHit;
    endsequence
    sequence s_ack_held;
        oe_ff && (st_ff == sshi_pkg::S_AACK);
    endsequence
    a_addr_ack: assert property ((s_addr_hit and (!startDet && !stopDet)) // R13
        |=> s_ack_held)
        else $error("own address not acknowledged");
    a_ara_ignore: assert property (addrEnd && !araEn_ff && !ownHit |=> !oe_ff) // R24
        else $error("alert address answered while disabled");
    a_no_commit: assert property (stopDet && !wrPend_ff |=> $stable(sel_ff) && $stable(wake_ff))
        // R26
        else $error("registers changed without complete write");
    a_smb_timeout: assert property (smbTimeout && !startDet
        |=> st_ff == sshi_pkg::S_IDLE && !oe_ff) // R22
        else $error("SMBus timeout did not reset engine");
    a_force_pulse: assert property (wrRst |=> softRst_ff ##1 !softRst_ff) // R6
        else $error("forced reset not a single pulse");
    a_sel_kept: assert property (softRst_ff |=> $stable(sel_ff) && !araEn_ff) // R7
        else $error("forced reset disturbed selection");

    // ==================================================
    // Oscillator low power and wake
    logic oscRun_ff;
    wire gpioWake = wake_ff[sshi_pkg::WK_GPIO_BIT] & |(gpioEv & gpioFuncSel & gpioIrqEn); // R1
    wire lineWake = (wake_ff[sshi_pkg::WK_DAT_BIT] & sdaEdge) |
                    (wake_ff[sshi_pkg::WK_CLK_BIT] & (sclRise | sclFall)); // R2
    wire wakeEv = gpioWake | lineWake;
    wire stopOk = oscLp_ff & (st_ff == sshi_pkg::S_IDLE) & sclS & sdaS &
                  ~irqPending & ~lineEdge & ~wakeEv; // R25

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oscRun_ff <= 1'b1;
        end else if (softRst_ff) begin
            oscRun_ff <= 1'b1;
        end else if (oscRun_ff) begin
            oscRun_ff <= ~stopOk; // R25
        end else begin
            oscRun_ff <= wakeEv | ~oscLp_ff; // R1 R2
        end
    end

    a_gpio_wake: assert property (!oscRun_ff && gpioWake && !softRst_ff |=> oscRun_ff) // R1
        else $error("pin interrupt did not wake oscillator");
    a_line_wake: assert property (!oscRun_ff && lineWake |=> oscRun_ff) // R2
        else $error("bus line edge did not wake oscillator");
    a_stay_off: assert property (!oscRun_ff && oscLp_ff && !wakeEv && !softRst_ff
        |=> !oscRun_ff) // R1
        else $error("oscillator woke without enabled event");
    a_osc_stop: assert property ($fell(oscRun_ff)
        |-> $past(st_ff == sshi_pkg::S_IDLE) && $past(!irqPending)) // R25
        else $error("oscillator stopped while busy");

    // ==================================================
    // Registered outputs
    logic smbAct_ff;
    logic compAct_ff;
    logic [GPIO_N-1:0] gpioEv_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            smbAct_ff <= 1'b0;
            compAct_ff <= 1'b0;
            gpioEv_ff <= '0;
        end else begin
            smbAct_ff <= smbOn & (forced | busType_ff == sshi_pkg::BUS_SMB);
            compAct_ff <= compOn;
            gpioEv_ff <= gpioEv; // R3
        end
    end

    assign smbusDataOut = 1'b0; // Open drain drives low only
    assign smbusDataOe = oe_ff;
    assign oscRun = oscRun_ff;
    assign smbusActive = smbAct_ff;
    assign companionActive = compAct_ff;
    assign gpioEdgeEvent = gpioEv_ff;
    assign slaveAddr = myAddr_ff;
    assign addrLocked = locked_ff;
endmodule

// *** test/sshi_master_model.sv ***
`timescale 1ns/10ps
// ==========
// Bus master: 800 ns bit, open-drain data with pull-up
module sshi_master_model (
    input wire logic devOe,
    output logic scl,
    output logic sda
);
    logic mSda = 1'h1;
    initial scl = 1'h1;
    // Wired-and of master and device
    assign sda = mSda & ~devOe;
    // One bit: data moves while clock low, read while high
    task automatic bit_io(input logic b, output logic q);
        #300 mSda = b;
        #300 scl = 1'h1;
        #100 q = sda;
        #100 scl = 1'h0;
    endtask
    // Start or repeated start
    task automatic start();
        mSda = 1'h1;
        #300 scl = 1'h1;
        #300 mSda = 1'h0;
        #300 scl = 1'h0;
    endtask
    task automatic stop();
        #300 mSda = 1'h0;
        #300 scl = 1'h1;
        #300 mSda = 1'h1;
    endtask
    // Byte plus acknowledge slot, MSB first
    task automatic xfer(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--) begin
            bit_io(o[k], i[k]);
        end
    endtask
endmodule

// *** test/test_smbus_slave_host_interface.sv ***
`timescale 1ns/10ps
module test_smbus_slave_host_interface;
    // ==========
    // Bench state
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] pin = 8'h00;
    logic [7:0] dir = 8'h00;
    logic [7:0] rise = 8'h00;
    logic [7:0] fall = 8'h00;
    logic irq = 1'h0;
    logic [7:0] ev, acc, v;
    logic [31:0] seed = 32'hA69B177C;
    logic scl, sda, oe, smbOn, osc, comp, lk;
    logic [6:0] sAddr;
    logic [8:0] r;
    logic [7:0] ids [6] = '{8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'hF6, 8'h10};
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    sshi_master_model mst (.devOe(oe), .scl(scl), .sda(sda));
    sshi_top #(.DET_SMB_CYC(2000), .IDLE_SMB_CYC(1500)) uut (.clk(clk), .rst_b(rst_b),
        .smbusClockPin(scl), .smbusDataPin(sda), .smbusDataOut(), .smbusDataOe(oe),
        .addrSelectPin(1'h0), .gpioPin(pin), .gpioFuncSel(8'hFF), .gpioIrqEn(8'hFF),
        .gpioDirIn(dir), .gpioRiseEn(rise), .gpioFallEn(fall), .irqPending(irq),
        .oscRun(osc), .smbusActive(smbOn), .companionActive(comp), .gpioEdgeEvent(ev),
        .slaveAddr(sAddr), .addrLocked(lk));
    // Helpers: random source, expected register contents
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] expReg(input logic [7:0] a);
        case (a)
            8'hFC: return 8'hA7;
            8'hFD: return 8'h03;
            8'hFE: return 8'h2D;
            8'hFF: return 8'h6B;
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input logic [8:0] got, input logic [8:0] want);
        check_count++;
        if (got !== want) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Write byte; r[0] keeps the address acknowledge
    task automatic wr(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d);
        logic [8:0] t;
        @(posedge clk) #5 mst.start();
        mst.xfer({dv, 2'h1}, r);
        mst.xfer({a, 1'h1}, t);
        mst.xfer({d, 1'h1}, t);
        mst.stop();
    endtask
    // Mode 0 send, 1 read byte, 2 receive; in modes 1 and 2 q is {data, read address ack}
    task automatic txn(input logic [6:0] dv, input logic [7:0] a, input int md,
        output logic [8:0] q);
        logic [8:0] t;
        @(posedge clk) #5 mst.start();
        if (md != 2) begin
            mst.xfer({8'h70, 1'h1}, q);
            mst.xfer({a, 1'h1}, q);
            if (md == 1) mst.start();
        end
        if (md != 0) begin
            mst.xfer({dv, 2'h3}, t);
            mst.xfer(9'h1FF, q);
            q[0] = t[0];
        end
        mst.stop();
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            summarize();
        end
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        #5 rst_b = 1'h1;
        foreach (ids[k]) begin
            txn(7'h38, ids[k], 1, r);
            chk(r, {expReg(ids[k]), 1'h0});
        end
        chk({1'h0, lk, sAddr}, 9'h0B8);
        $display("identity test done");
        seed = xs(seed);
        v = {3'h0, seed[4], 4'h3};
        wr(7'h38, 8'hFA, v);
        txn(7'h38, 8'hFA, 1, r);
        chk(r, {v, 1'h0});
        chk({7'h00, comp, smbOn}, 9'h001);
        txn(7'h38, 8'hFC, 0, r);
        txn(7'h38, 8'h00, 2, r);
        chk(r, {8'hA7, 1'h0});
        wr(7'h50, 8'hFB, 8'h07);
        chk({8'h00, r[0]}, 9'h001);
        txn(7'h38, 8'hFB, 1, r);
        chk(r, 9'h000);
        wr(7'h38, 8'hFB, {5'h00, seed[9:7]});
        txn(7'h38, 8'hFB, 1, r);
        chk(r, {5'h00, seed[9:7], 1'h0});
        $display("register test done");
        wr(7'h38, 8'hFA, 8'h03);
        txn(7'h0C, 8'h00, 2, r);
        chk(r, 9'h1FF);
        wr(7'h38, 8'hFA, 8'h13);
        txn(7'h0C, 8'h00, 2, r);
        chk(r, 9'h0E0);
        wr(7'h38, 8'hF5, 8'h01);
        txn(7'h38, 8'hFA, 1, r);
        chk(r, 9'h006);
        txn(7'h38, 8'hFB, 1, r);
        chk(r, 9'h000);
        $display("alert and reset test done");
        irq = 1'h1;
        wr(7'h38, 8'hFB, 8'h02);
        wr(7'h38, 8'hFA, 8'h07);
        repeat (10) @(posedge clk);
        #5 chk({8'h00, osc}, 9'h001);
        irq = 1'h0;
        repeat (10) @(posedge clk);
        #5 chk({8'h00, osc}, 9'h000);
        mst.start();
        repeat (6) @(posedge clk);
        #5 chk({8'h00, osc}, 9'h001);
        repeat (1600) @(posedge clk);
        #5 mst.stop();
        wr(7'h38, 8'hFA, 8'h03);
        $display("oscillator test done");
        seed = xs(seed);
        @(posedge clk) #5 dir = seed[7:0];
        rise = seed[15:8];
        acc = 8'h00;
        @(posedge clk) #5 pin = 8'hFF;
        repeat (8) begin
            @(posedge clk) #1 acc = acc | ev;
        end
        chk({1'h0, acc}, {1'h0, dir & rise});
        @(posedge clk) #5 fall = seed[23:16];
        acc = 8'h00;
        @(posedge clk) #5 pin = 8'h00;
        repeat (8) begin
            @(posedge clk) #1 acc = acc | ev;
        end
        chk({1'h0, acc}, {1'h0, dir & fall});
        $display("edge test done");
        summarize();
    end
endmodule
